// File: bench/host_master_model.sv
// register port master model standing in for the airbag host controller
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
   // clock
   input  wire logic                 core_clk,
   // register port
   output var accel_regs_pkg::reg_req_t reg_req,
   input  wire logic [7:0]           reg_rdata,
   input  wire logic                 reg_rvalid
);
   import accel_regs_pkg::*;
   initial reg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'hff, wdata: 8'hff};
   // idle lines show the inverse of the last value, so stale data is never read as valid
   task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_req = '{rd: r, wr: !r, addr: a, wdata: d};
      @(posedge core_clk);
      #1;
      reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask : access
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      access(1'b0, a, d);
   endtask : reg_write
   // answer stands one cycle after the strobe edge only
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      access(1'b1, a, 8'h00);
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask : reg_read
endmodule : host_master_model
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the arming and status register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import accel_regs_pkg::*;
   // short tick so the wrap test stays brief
   localparam int TICKS = 8;
   logic          core_clk = 1'b0;
   logic          rst = 1'b1;
   reg_req_t      reg_req;
   logic [7:0]    reg_rdata;
   logic          reg_rvalid;
   logic          init_complete_lock = 1'b0;
   logic          init_done = 1'b0;
   fault_events_t faults = '0;
   logic          corr_load = 1'b0;
   logic [7:0]    corr_in = 8'h00;
   arm_config_t   arm_cfg = '0;
   logic [63:0]   otp_shadow = 64'h0123_4567_89ab_cdef;
   logic [2:0]    otp_crc_stored = 3'h0;
   logic [15:0]   writable_other = 16'h5a3c;
   logic [2:0]    writable_crc_stored = 3'h0;
   arm_setup_t    arm_setup;
   logic          internal_data_error_flag;
   logic          initializing_flag;
   int            error_cnt = 0;
   int            n_tests = 0;
   logic [7:0]    a, b, c;
   logic [7:0]    tp [4] = '{8'ha5, 8'h00, 8'h00, 8'h01};
   logic [7:0]    tn [4] = '{8'h00, 8'hff, 8'h00, 8'h80};
   logic [2:0]    te [4] = '{3'h5, 3'h3, 3'h0, 3'h7};
   logic [5:0]    tc [4] = '{6'h12, 6'h21, 6'h0f, 6'h2f};
   logic [9:0]    tw [4] = '{10'h102, 10'h063, 10'h000, 10'h1ef};
   logic [7:0]    fm [3] = '{8'h40, 8'h02, 8'h08};

   always #12.5 core_clk = ~core_clk;

   accel_arming_status_regs #(.TICK_COUNT(TICKS)) uut (
      .core_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .init_complete_lock, .init_done,
      .faults, .corr_load, .corr_in, .arm_cfg, .otp_shadow, .otp_crc_stored,
      .writable_other, .writable_crc_stored, .arm_setup, .internal_data_error_flag,
      .initializing_flag
   );
   host_master_model host (.core_clk, .reg_req, .reg_rdata, .reg_rvalid);

   // serial crc, msb first, bytes from index 0 upward
   function automatic logic [2:0] crc3(input logic [79:0] v, input int n);
      logic [2:0] r;
      logic       fb;
      r = CRC_SEED;
      for (int i = 0; i < n * 8; i++) begin
         fb = r[2] ^ v[(i / 8) * 8 + 7 - (i % 8)];
         r = {r[1], r[0] ^ fb, fb};
      end
      return r;
   endfunction : crc3
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic rc(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      host.reg_read(addr, d);
      check(d, exp);
   endtask : rc
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cycles
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      otp_crc_stored = crc3({16'h0000, otp_shadow}, 8);
      cycles(10);
      rst = 1'b0;
      rc(ADDR_TICK_CNT, 8'h00);
      rc(ADDR_POS_THR, 8'h00);
      rc(ADDR_NEG_THR, 8'h00);
      rc(ADDR_CORR_VAL, 8'h00);
      rc(8'h11, 8'h00);
      host.reg_write(ADDR_RSVD_A, 8'h00);
      rc(ADDR_RSVD_A, 8'h00);
      rc(ADDR_RSVD_B, 8'h00);
      rc(ADDR_STATUS, 8'h11);
      rc(ADDR_STATUS, 8'h11);
      done("reset values");
      for (int i = 0; i < 4; i++) begin
         host.reg_write(ADDR_POS_THR, tp[i]);
         host.reg_write(ADDR_NEG_THR, tn[i]);
         arm_cfg = arm_config_t'(tc[i]);
         cycles(2);
         check({arm_setup.pos_enable, arm_setup.neg_enable, arm_setup.pin_enable}, te[i]);
         check({arm_setup.pos_threshold, arm_setup.neg_threshold}, {tp[i], tn[i]});
         check({arm_setup.pos_window, arm_setup.neg_window}, tw[i]);
         rc(ADDR_POS_THR, tp[i]);
         rc(ADDR_NEG_THR, tn[i]);
      end
      done("thresholds");
      corr_in = 8'h3c;
      corr_load = 1'b1;
      cycles(1);
      corr_load = 1'b0;
      host.reg_write(ADDR_CORR_VAL, 8'hc3);
      host.reg_write(ADDR_STATUS, 8'hff);
      rc(ADDR_CORR_VAL, 8'h3c);
      rc(ADDR_STATUS, 8'h11);
      done("read only");
      init_done = 1'b1;
      cycles(1);
      init_done = 1'b0;
      rc(ADDR_STATUS, 8'h01);
      rc(ADDR_STATUS, 8'h00);
      check(initializing_flag, 1'b0);
      for (int k = 0; k < 3; k++) begin
         faults = fault_events_t'(3'b001 << k);
         cycles(1);
         faults = '0;
         rc(ADDR_STATUS, fm[k]);
         rc(ADDR_STATUS, 8'h00);
      end
      done("status flags");
      host.reg_read(ADDR_TICK_CNT, a);
      cycles(30);
      host.reg_read(ADDR_TICK_CNT, b);
      cycles(2054);
      host.reg_read(ADDR_TICK_CNT, c);
      check(8'(b - a), 8'h04);
      check(8'(c - b), 8'h01);
      done("counter");
      // average mode, largest positive code: windows 16 and 8
      arm_cfg = arm_config_t'(6'h1b);
      cycles(2);
      check({arm_setup.pos_window, arm_setup.neg_window}, 10'h208);
      done("largest window");
      writable_crc_stored = crc3({48'h0, tn[3], tp[3], writable_other}, 4);
      init_complete_lock = 1'b1;
      cycles(3);
      check(internal_data_error_flag, 1'b0);
      host.reg_write(ADDR_POS_THR, 8'h77);
      rc(ADDR_POS_THR, 8'h01);
      writable_crc_stored = ~writable_crc_stored;
      cycles(3);
      rc(ADDR_STATUS, 8'h40);
      rc(ADDR_STATUS, 8'h40);
      // unlocked: a wrong writable check value must be ignored
      init_complete_lock = 1'b0;
      cycles(2);
      rc(ADDR_STATUS, 8'h40);
      rc(ADDR_STATUS, 8'h00);
      otp_crc_stored = ~otp_crc_stored;
      cycles(3);
      rc(ADDR_STATUS, 8'h40);
      rc(ADDR_STATUS, 8'h40);
      otp_crc_stored = ~otp_crc_stored;
      done("crc");
      rst = 1'b1;
      cycles(2);
      rst = 1'b0;
      rc(ADDR_STATUS, 8'h11);
      rc(ADDR_POS_THR, 8'h00);
      done("second reset");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire

// File: logic/accel_arming_status_regs.sv
// arming thresholds, read-to-clear status, oscillator monitor and crc checks
`timescale 1ns/1ps
`default_nettype none

// Operation
// - threshold writes accepted only before init lock
// - thresholds covered by writable register crc
// - thresholds are independent unsigned 8-bit values
// - zero threshold disables that polarity only
// - both zero disables arming and pin
// - status read-only; read clears transient flags
// - bit 6 internal error, cleared on read
// - persisting crc faults re-raise internal error
// - bit 4 initializing until init completes
// - bit 3 output mismatch, cleared on read
// - bit 1 offset limit, cleared on read
// - bit 0 set during post-reset initialization
// - bits 7 and 5 unused; bit 2 zero
// - free-running 8-bit counter every 128 us
// - read-only latest offset correction value
// - otp shadow crc, x3+x+1, seed 111
// - writable crc checked only while locked
// - mode bits pick average or count windows
module accel_arming_status_regs
   import accel_regs_pkg::*;
#(
   parameter int OTP_BYTES  = 8,
   parameter int EXT_BYTES  = 2,
   parameter int TICK_COUNT = accel_regs_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire  logic                             core_clk,
   input  wire  logic                             rst,
   // register access
   input  wire  accel_regs_pkg::reg_req_t         reg_req,
   output logic [7:0]                             reg_rdata,
   output logic                                   reg_rvalid,
   // device context
   input  wire  logic                             init_complete_lock,
   input  wire  logic                             init_done,
   input  wire  accel_regs_pkg::fault_events_t    faults,
   input  wire  logic                             corr_load,
   input  wire  logic [7:0]                       corr_in,
   input  wire  accel_regs_pkg::arm_config_t      arm_cfg,
   // crc sources, byte 0 at lowest address
   input  wire  logic [OTP_BYTES*8-1:0]           otp_shadow,
   input  wire  logic [2:0]                       otp_crc_stored,
   input  wire  logic [EXT_BYTES*8-1:0]           writable_other,
   input  wire  logic [2:0]                       writable_crc_stored,
   // arming setup and status view
   output accel_regs_pkg::arm_setup_t             arm_setup,
   output logic                                   internal_data_error_flag,
   output logic                                   initializing_flag
);
   import accel_regs_pkg::*;

   localparam int TICK_W = $clog2(TICK_COUNT);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);
   localparam int WR_BYTES = EXT_BYTES + 2;

   logic [7:0]        positive_arming_threshold;
   logic [7:0]        negative_arming_threshold;
   logic [7:0]        oscillator_tick_counter;
   logic [7:0]        offset_correction_value;
   logic [7:0]        reserved_slot_a;
   logic [7:0]        reserved_slot_b;
   logic [TICK_W-1:0] prescale;
   logic              output_mismatch_flag;
   logic              offset_error_flag;
   logic              reset_occurred_flag;
   init_state_t       init_state;
   arm_setup_t        arm_q;

   logic [7:0]        next_pos_thr;
   logic [7:0]        next_neg_thr;
   logic [7:0]        next_tick_counter;
   logic [7:0]        next_corr;
   logic [7:0]        next_rsvd_a;
   logic [7:0]        next_rsvd_b;
   logic [TICK_W-1:0] next_prescale;
   logic              next_int_err;
   logic              next_mismatch;
   logic              next_offset;
   logic              next_reset_occ;
   init_state_t       next_init_state;
   logic [7:0]        next_rdata;
   logic              next_rvalid;
   arm_setup_t        next_arm;

   logic [7:0]        status_view;
   logic              status_read;
   logic              thr_unlocked;
   logic [2:0]        otp_crc;
   logic [2:0]        wr_crc;
   logic              otp_fault;
   logic              wr_fault;
   logic [WR_BYTES*8-1:0] wr_image;

   // crc over bytes, ascending address, msb first
   function automatic logic [2:0] crc_step(input logic [2:0] c, input logic [7:0] b);
      logic [2:0] r;
      logic       fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[2] ^ b[i];
         r  = {r[1:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 3'h0);
      end
      return r;
   endfunction : crc_step

   // extra writable bytes sit below the thresholds in address order
   assign wr_image = {negative_arming_threshold, positive_arming_threshold, writable_other};

   always_comb begin
      otp_crc = CRC_SEED;
      wr_crc  = CRC_SEED;
      for (int k = 0; k < OTP_BYTES; k++) begin
         otp_crc = crc_step(otp_crc, otp_shadow[k*8 +: 8]);
      end
      for (int k = 0; k < WR_BYTES; k++) begin
         wr_crc = crc_step(wr_crc, wr_image[k*8 +: 8]);
      end
   end

   // checked every cycle, so a persisting fault re-raises after a read
   assign otp_fault = otp_crc != otp_crc_stored;
   assign wr_fault  = init_complete_lock && (wr_crc != writable_crc_stored);

   assign status_read  = reg_req.rd && (reg_req.addr == ADDR_STATUS);
   assign thr_unlocked = reg_req.wr && !init_complete_lock;

   always_comb begin
      status_view                    = BYTE_ZERO;
      status_view[STAT_INT_ERR_BIT]  = internal_data_error_flag;
      status_view[STAT_INIT_BIT]     = initializing_flag;
      status_view[STAT_MISMATCH_BIT] = output_mismatch_flag;
      status_view[STAT_OFFSET_BIT]   = offset_error_flag;
      status_view[STAT_RESET_BIT]    = reset_occurred_flag;
   end

   // register writes; read-only slots have no write path
   always_comb begin
      next_pos_thr = positive_arming_threshold;
      next_neg_thr = negative_arming_threshold;
      next_rsvd_a  = reserved_slot_a;
      next_rsvd_b  = reserved_slot_b;
      if (thr_unlocked && reg_req.addr == ADDR_POS_THR) begin
         next_pos_thr = reg_req.wdata;
      end
      if (thr_unlocked && reg_req.addr == ADDR_NEG_THR) begin
         next_neg_thr = reg_req.wdata;
      end
      // stored as written; the host is expected to keep these zero
      if (reg_req.wr && reg_req.addr == ADDR_RSVD_A) begin
         next_rsvd_a = reg_req.wdata;
      end
      if (reg_req.wr && reg_req.addr == ADDR_RSVD_B) begin
         next_rsvd_b = reg_req.wdata;
      end
   end

   // status flags: a set in the read cycle wins over the clear
   always_comb begin
      next_int_err    = (internal_data_error_flag && !status_read)
                        || otp_fault || wr_fault || faults.internal_fault;
      next_mismatch   = (output_mismatch_flag && !status_read) || faults.mismatch_fault;
      next_offset     = (offset_error_flag && !status_read) || faults.offset_limit_hit;
      next_reset_occ  = (reset_occurred_flag && !status_read)
                        || (init_state == ST_INITIALIZING);
      next_init_state = init_state;
      case (init_state)
         ST_INITIALIZING: begin
            if (init_done) begin
               next_init_state = ST_RUNNING;
            end
         end
         ST_RUNNING: next_init_state = ST_RUNNING;
         default:    next_init_state = ST_INITIALIZING;
      endcase
   end

   assign initializing_flag = init_state == ST_INITIALIZING;

   // oscillator monitor and offset correction capture
   always_comb begin
      next_prescale     = prescale + TICK_W'(1);
      next_tick_counter = oscillator_tick_counter;
      if (prescale == TICK_LAST) begin
         next_prescale     = '0;
         next_tick_counter = oscillator_tick_counter + 8'h01;
      end
      next_corr = corr_load ? corr_in : offset_correction_value;
   end

   // read answer one cycle after the strobe
   always_comb begin
      next_rvalid = reg_req.rd;
      next_rdata  = BYTE_ZERO;
      if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_POS_THR:  next_rdata = positive_arming_threshold;
            ADDR_NEG_THR:  next_rdata = negative_arming_threshold;
            ADDR_STATUS:   next_rdata = status_view;
            ADDR_TICK_CNT: next_rdata = oscillator_tick_counter;
            ADDR_CORR_VAL: next_rdata = offset_correction_value;
            ADDR_RSVD_A:   next_rdata = reserved_slot_a;
            ADDR_RSVD_B:   next_rdata = reserved_slot_b;
            default:       next_rdata = BYTE_ZERO;
         endcase
      end
   end

   // arming setup toward the comparison engine
   always_comb begin
      next_arm               = '0;
      next_arm.pos_threshold = positive_arming_threshold;
      next_arm.neg_threshold = negative_arming_threshold;
      next_arm.pos_enable    = positive_arming_threshold != THR_DISABLED;
      next_arm.neg_enable    = negative_arming_threshold != THR_DISABLED;
      next_arm.pin_enable    = next_arm.pos_enable || next_arm.neg_enable;
      case (arm_cfg.mode)
         MODE_AVERAGE: begin
            // shift two by the code itself: a two-bit code plus one would wrap at code 3
            next_arm.pos_window = {WINDOW_ONE[3:0], 1'b0} << arm_cfg.aws_pos;
            next_arm.neg_window = {WINDOW_ONE[3:0], 1'b0} << arm_cfg.aws_neg;
         end
         MODE_COUNT: begin
            next_arm.pos_window = ({WINDOW_ONE[3:0], 1'b0} << arm_cfg.aws_pos) - WINDOW_ONE;
            next_arm.neg_window = next_arm.pos_window;
         end
         default: begin
            next_arm.pos_window = '0;
            next_arm.neg_window = '0;
         end
      endcase
   end

   assign arm_setup = arm_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         positive_arming_threshold <= THR_RESET;
         negative_arming_threshold <= THR_RESET;
         reserved_slot_a           <= BYTE_ZERO;
         reserved_slot_b           <= BYTE_ZERO;
         oscillator_tick_counter   <= BYTE_ZERO;
         offset_correction_value   <= BYTE_ZERO;
         prescale                  <= '0;
         internal_data_error_flag  <= 1'b0;
         output_mismatch_flag      <= 1'b0;
         offset_error_flag         <= 1'b0;
         reset_occurred_flag       <= 1'b1;
         init_state                <= ST_INITIALIZING;
         reg_rdata                 <= BYTE_ZERO;
         reg_rvalid                <= 1'b0;
         arm_q                     <= '0;
      end else begin
         positive_arming_threshold <= next_pos_thr;
         negative_arming_threshold <= next_neg_thr;
         reserved_slot_a           <= next_rsvd_a;
         reserved_slot_b           <= next_rsvd_b;
         oscillator_tick_counter   <= next_tick_counter;
         offset_correction_value   <= next_corr;
         prescale                  <= next_prescale;
         internal_data_error_flag  <= next_int_err;
         output_mismatch_flag      <= next_mismatch;
         offset_error_flag         <= next_offset;
         reset_occurred_flag       <= next_reset_occ;
         init_state                <= next_init_state;
         reg_rdata                 <= next_rdata;
         reg_rvalid                <= next_rvalid;
         arm_q                     <= next_arm;
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_status_read_quiet;
      status_read && !faults.mismatch_fault;
   endsequence

   sequence s_flag_gone;
      reg_rvalid && !output_mismatch_flag;
   endsequence

   a_thr_locked: assert property (
      init_complete_lock && reg_req.wr && reg_req.addr == ADDR_POS_THR
      |=> $stable(positive_arming_threshold))
      else $error("threshold changed after lock");

   a_thr_written: assert property (
      !init_complete_lock && reg_req.wr && reg_req.addr == ADDR_NEG_THR
      |=> negative_arming_threshold == $past(reg_req.wdata))
      else $error("unlocked threshold write lost");

   a_one_polarity: assert property (
      positive_arming_threshold == THR_DISABLED && negative_arming_threshold != THR_DISABLED
      |=> !arm_setup.pos_enable && arm_setup.neg_enable && arm_setup.pin_enable)
      else $error("single polarity disable wrong");

   a_both_zero: assert property (
      positive_arming_threshold == THR_DISABLED && negative_arming_threshold == THR_DISABLED
      |=> !arm_setup.pin_enable)
      else $error("arming pin not disabled");

   a_mismatch_clear: assert property (
      s_status_read_quiet |=> s_flag_gone)
      else $error("mismatch flag survived status read");

   a_otp_fault: assert property (
      otp_fault |=> internal_data_error_flag [*2])
      else $error("otp crc fault not flagged");

   a_wr_crc_gate: assert property (
      !init_complete_lock && !otp_fault && !faults.internal_fault && status_read
      |=> !internal_data_error_flag)
      else $error("writable crc checked while unlocked");

   a_init_hold: assert property (
      initializing_flag && !init_done |=> initializing_flag && reset_occurred_flag)
      else $error("init flag dropped early");

   a_status_bits: assert property (
      status_read |=> reg_rvalid && reg_rdata[2] == 1'b0
                      && reg_rdata[STAT_INIT_BIT] == $past(initializing_flag))
      else $error("status read view wrong");

   a_counter_step: assert property (
      prescale == TICK_LAST |=> oscillator_tick_counter == $past(oscillator_tick_counter) + 8'h01)
      else $error("tick counter missed a step");

   a_ro_ignored: assert property (
      reg_req.wr && reg_req.addr == ADDR_CORR_VAL && !corr_load
      |=> $stable(offset_correction_value))
      else $error("read-only register written");

endmodule : accel_arming_status_regs

`default_nettype wire

// File: pkg/accel_regs_pkg.sv
// constants, field layouts and carrier types of the arming and status register bank
package accel_regs_pkg;

   // register offsets
   localparam logic [7:0] ADDR_POS_THR   = 8'h10;
   localparam logic [7:0] ADDR_NEG_THR   = 8'h12;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;
   localparam logic [7:0] ADDR_TICK_CNT  = 8'h15;
   localparam logic [7:0] ADDR_CORR_VAL  = 8'h16;
   localparam logic [7:0] ADDR_RSVD_A    = 8'h1C;
   localparam logic [7:0] ADDR_RSVD_B    = 8'h1D;

   // reset and disable values
   localparam logic [7:0] THR_RESET      = 8'h00;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [7:0] THR_DISABLED   = 8'h00;

   // status bit positions
   localparam int STAT_INT_ERR_BIT       = 6;
   localparam int STAT_INIT_BIT          = 4;
   localparam int STAT_MISMATCH_BIT      = 3;
   localparam int STAT_OFFSET_BIT        = 1;
   localparam int STAT_RESET_BIT         = 0;

   // crc: x^3 + x + 1, seed 111
   localparam logic [2:0] CRC_SEED       = 3'h7;
   localparam logic [2:0] CRC_POLY_LOW   = 3'h3;

   // oscillator monitor tick
   localparam int CORE_CLK_MHZ           = 40;
   localparam int TICK_PERIOD_US         = 128;
   localparam int TICK_CYCLES            = TICK_PERIOD_US * CORE_CLK_MHZ;

   // arming mode selector codes and unit window
   localparam logic [1:0] MODE_AVERAGE   = 2'h1;
   localparam logic [1:0] MODE_COUNT     = 2'h2;
   localparam logic [4:0] WINDOW_ONE     = 5'h01;

   typedef enum logic {ST_INITIALIZING, ST_RUNNING} init_state_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic mismatch_fault;
      logic offset_limit_hit;
      logic internal_fault;
   } fault_events_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] aws_neg;
      logic [1:0] aws_pos;
   } arm_config_t;

   typedef struct packed {
      logic       pos_enable;
      logic       neg_enable;
      logic       pin_enable;
      logic [7:0] pos_threshold;
      logic [7:0] neg_threshold;
      logic [4:0] pos_window;
      logic [4:0] neg_window;
   } arm_setup_t;

endpackage : accel_regs_pkg
